// ---- logic/pc_trace_defs.vh ----
// Purpose: shared constants of the program-counter trace output unit
// Assumes: included by bare name from every design file of the unit
// Notes:   definitions only, no logic
`ifndef PC_TRACE_DEFS_VH
`define PC_TRACE_DEFS_VH

// ****************************************************************
// serial field sizes
// ****************************************************************
`define TRC_ADDR_BITS 30
`define TRC_ADDR_CNT_BITS 5
`define TRC_EXC_BITS 4
`define TRC_EXC_CNT_BITS 3

// address window: plain mode starts at bit 2, compressed mode at bit 1
`define TRC_ADDR_LO_PLAIN 2
`define TRC_ADDR_HI_PLAIN 31
`define TRC_ADDR_LO_COMP 1
`define TRC_ADDR_HI_COMP 30

// ****************************************************************
// status codes on the 3-bit status output
// ****************************************************************
`define CODE_TRIGGER_STALL 3'h2
`define CODE_TRIGGER_SEQ 3'h1
`define CODE_SEQUENTIAL 3'h0
`define CODE_STALL 3'h3
`define CODE_JUMP_TAKEN 3'h4
`define CODE_BRANCH_TAKEN 3'h5
`define CODE_EXCEPTION 3'h6
`define CODE_DEBUG_ENTRY 3'h7

// ****************************************************************
// reset values
// ****************************************************************
`define RST_STATUS `CODE_STALL
`define RST_BIT 1'b0

`endif

// ---- logic/edge_sync.v ----
// Purpose: brings the trace clock into the core clock domain
// Assumes: input is asynchronous to clock and slower than clock / 2
// Notes:   rise is a one-cycle pulse per rising edge of the input
`timescale 1ns/1ps
`default_nettype none
`include "pc_trace_defs.vh"

module edge_sync (
    // clock and reset
    input wire clock,
    input wire nrst,
    // asynchronous level in, edge pulse out
    input wire async_in,
    output wire rise
);

    reg meta;
    reg stable;
    reg stable_d;

    // two-flop synchroniser plus one stage for the edge detector
    always @(posedge clock) begin
        if (!nrst) begin
            meta <= `RST_BIT;
            stable <= `RST_BIT;
            stable_d <= `RST_BIT;
        end else begin
            meta <= async_in;
            stable <= meta;
            stable_d <= stable;
        end
    end

    assign rise = stable & ~stable_d; // rising edge seen

endmodule // edge_sync
`default_nettype wire

// ---- logic/trace_shifter.v ----
// Purpose: loadable serialiser, least significant bit first
// Assumes: load and tick are single-cycle pulses of the core clock
// Notes:   busy stays high for W unheld tick periods after a load
`timescale 1ns/1ps
`default_nettype none
`include "pc_trace_defs.vh"

module trace_shifter #(
    parameter W = 4,
    parameter CW = 3
) (
    // clock and reset
    input wire clock,
    input wire nrst,
    // control
    input wire tick,
    input wire load,
    input wire hold,
    input wire [W-1:0] load_data,
    // status and serial bit
    output wire busy,
    output wire bit_out
);

    localparam [CW-1:0] FULL = W[CW-1:0];

    reg [W-1:0] sr;
    reg [CW-1:0] left;

    // a load restarts the word; otherwise shift once per tick while busy and not held
    always @(posedge clock) begin
        if (!nrst) begin
            sr <= {W{1'b0}};
            left <= {CW{1'b0}};
        end else if (load) begin
            sr <= load_data;
            left <= FULL;
        end else if (tick && busy && !hold) begin
            sr <= {1'b0, sr[W-1:1]};
            left <= left - 1'b1;
        end
    end

    assign busy = (left != {CW{1'b0}});
    assign bit_out = sr[0];

endmodule // trace_shifter
`default_nettype wire

// ---- logic/pc_trace_output_unit.v ----
// Purpose: program-counter trace status and serial target output
// Assumes: core event inputs are on clock and valid at each trace tick
// Notes:   one trace tick per rising edge of the sampled trace clock
`timescale 1ns/1ps
`default_nettype none
`include "pc_trace_defs.vh"

module pc_trace_output_unit #(
    parameter [2:0] SEQUENTIAL_CODE = `CODE_SEQUENTIAL,
    parameter [2:0] STALL_CODE = `CODE_STALL,
    parameter [2:0] JUMP_TAKEN_CODE = `CODE_JUMP_TAKEN,
    parameter [2:0] BRANCH_TAKEN_CODE = `CODE_BRANCH_TAKEN,
    parameter [2:0] EXCEPTION_STATUS_CODE = `CODE_EXCEPTION,
    parameter [2:0] DEBUG_ENTRY_CODE = `CODE_DEBUG_ENTRY
) (
    // clock and reset
    input wire clock,
    input wire nrst,
    // trace clock from the pin, sampled here
    input wire trace_clk,
    // mode and configuration
    input wire trace_complete_select,
    input wire compressed_mode_strap,
    input wire debug_mode,
    // instruction events, taken at each trace tick
    input wire instr_valid,
    input wire slot_nullified,
    input wire jump_direct,
    input wire jump_indirect,
    input wire branch,
    input wire taken,
    input wire exception_return_instr,
    input wire exception_event,
    input wire [`TRC_EXC_BITS-1:0] exception_vector,
    input wire debug_exception,
    input wire trigger_match,
    input wire [31:0] target_pc,
    // serial test data that owns the pin in debug mode
    input wire serial_test_data,
    // core handshake
    output wire core_stall,
    // trace pins
    output reg [2:0] trace_status,
    output reg trace_pin,
    output reg pin_is_test_data
);

    // ************************************************************
    // trace clock sampling
    // ************************************************************
    wire tick;

    edge_sync u_edge_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(trace_clk),
        .rise(tick)
    );

    // ************************************************************
    // compressed mode strap, caught once after reset release
    // ************************************************************
    reg strap_done;
    reg compressed;

    always @(posedge clock) begin
        if (!nrst) begin
            strap_done <= 1'b0;
            compressed <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            compressed <= compressed_mode_strap;
        end
    end

    // 30-bit address window chosen by the strap
    wire [`TRC_ADDR_BITS-1:0] target_bits;
    assign target_bits = compressed ?
        target_pc[`TRC_ADDR_HI_COMP:`TRC_ADDR_LO_COMP] :
        target_pc[`TRC_ADDR_HI_PLAIN:`TRC_ADDR_LO_PLAIN];

    // ************************************************************
    // serialisers and pending-target buffer
    // ************************************************************
    wire addr_busy;
    wire addr_bit;
    wire exc_busy;
    wire exc_bit;
    reg pend_valid;
    reg [`TRC_ADDR_BITS-1:0] pend_addr;
    reg trig_pend;

    // decisions made from this tick's instruction
    reg [2:0] next_status;
    reg addr_load;
    reg exc_load;
    reg pend_set;
    reg pend_take;
    reg pend_clear;
    reg stall_req;
    reg trig_used;

    wire real_time;
    wire trig_any;
    wire is_jump;
    wire is_indirect;

    assign real_time = ~trace_complete_select;
    assign trig_any = trigger_match | trig_pend;
    assign is_indirect = jump_indirect | exception_return_instr;
    assign is_jump = exception_return_instr |
        ((jump_direct | jump_indirect | branch) & taken);

    wire [`TRC_ADDR_BITS-1:0] addr_src;
    assign addr_src = pend_take ? pend_addr : target_bits;

    // address serialiser, paused while a vector code goes out
    trace_shifter #(
        .W(`TRC_ADDR_BITS),
        .CW(`TRC_ADDR_CNT_BITS)
    ) u_addr_shifter (
        .clock(clock),
        .nrst(nrst),
        .tick(tick),
        .load(tick & (addr_load | pend_take)),
        // the bit shown before the vector is retired on the tick that starts
        // the vector, so the resumed output carries on with the next bit
        .hold(exc_busy),
        .load_data(addr_src),
        .busy(addr_busy),
        .bit_out(addr_bit)
    );

    // exception vector serialiser; a reload aborts the older code
    trace_shifter #(
        .W(`TRC_EXC_BITS),
        .CW(`TRC_EXC_CNT_BITS)
    ) u_exc_shifter (
        .clock(clock),
        .nrst(nrst),
        .tick(tick),
        .load(tick & exc_load),
        .hold(1'b0),
        .load_data(exception_vector),
        .busy(exc_busy),
        .bit_out(exc_bit)
    );

    // ************************************************************
    // per-instruction status and output arbitration
    // ************************************************************
    always @* begin
        next_status = STALL_CODE;
        addr_load = 1'b0;
        exc_load = 1'b0;
        pend_set = 1'b0;
        pend_take = 1'b0;
        pend_clear = 1'b0;
        stall_req = 1'b0;
        trig_used = 1'b0;
        if (debug_mode) begin
            // no new event is traced while the debug handler runs
            next_status = DEBUG_ENTRY_CODE;
        end else if (debug_exception) begin
            // no exception code and no vector for debug exceptions
            next_status = trig_any ? `CODE_TRIGGER_STALL : STALL_CODE;
            trig_used = 1'b1;
        end else if (!instr_valid || slot_nullified) begin
            // pipeline bubble or killed delay slot
            next_status = trig_any ? `CODE_TRIGGER_STALL : STALL_CODE;
            trig_used = 1'b1;
        end else if (exception_event) begin
            if (!real_time && exc_busy) begin
                // older vector must finish first in complete mode
                stall_req = 1'b1;
            end else begin
                next_status = EXCEPTION_STATUS_CODE;
                exc_load = 1'b1;
            end
        end else if (is_jump) begin
            if (is_indirect && real_time) begin
                next_status = JUMP_TAKEN_CODE;
                if (exc_busy) begin
                    pend_set = 1'b1;
                end else begin
                    addr_load = 1'b1;
                    pend_clear = 1'b1;
                end
            end else if (is_indirect) begin
                if (!addr_busy && !exc_busy && !pend_valid) begin
                    next_status = JUMP_TAKEN_CODE;
                    addr_load = 1'b1;
                end else if (!pend_valid) begin
                    next_status = JUMP_TAKEN_CODE;
                    pend_set = 1'b1;
                end else begin
                    stall_req = 1'b1;
                end
            end else if (addr_busy || pend_valid) begin
                // direct target dropped while another target is out
                next_status = BRANCH_TAKEN_CODE;
            end else if (exc_busy) begin
                next_status = JUMP_TAKEN_CODE;
                pend_set = 1'b1;
            end else begin
                next_status = JUMP_TAKEN_CODE;
                addr_load = 1'b1;
            end
        end else begin
            // sequential instruction or branch not taken
            next_status = trig_any ? `CODE_TRIGGER_SEQ : SEQUENTIAL_CODE;
            trig_used = 1'b1;
        end
        // start a buffered target once both serialisers are free
        if (pend_valid && !addr_busy && !exc_busy && !exc_load &&
            !addr_load && !pend_set) begin
            pend_take = 1'b1;
        end
    end

    // the core holds its instruction while this is high
    assign core_stall = stall_req & ~debug_mode;

    // ************************************************************
    // pending target buffer and trigger memory
    // ************************************************************
    always @(posedge clock) begin
        if (!nrst) begin
            pend_valid <= 1'b0;
            pend_addr <= {`TRC_ADDR_BITS{1'b0}};
            trig_pend <= 1'b0;
        end else if (tick) begin
            if (pend_set) begin
                pend_valid <= 1'b1;
                pend_addr <= target_bits;
            end else if (pend_take || pend_clear) begin
                pend_valid <= 1'b0;
            end
            // a trigger that landed on another code waits for seq/stall
            trig_pend <= trig_any & ~trig_used;
        end
    end

    // ************************************************************
    // pin registers; status updated on each trace tick, pin on every core clock
    // ************************************************************
    always @(posedge clock) begin
        if (!nrst) begin
            trace_status <= `RST_STATUS;
        end else if (tick) begin
            trace_status <= next_status;
        end
    end

    // shared pin: vector code first, then address, test data in debug
    always @(posedge clock) begin
        if (!nrst) begin
            trace_pin <= `RST_BIT;
            pin_is_test_data <= 1'b0;
        end else begin
            pin_is_test_data <= debug_mode;
            if (debug_mode) begin
                trace_pin <= serial_test_data;
            end else if (exc_busy) begin
                trace_pin <= exc_bit;
            end else if (addr_busy) begin
                trace_pin <= addr_bit;
            end else begin
                trace_pin <= `RST_BIT;
            end
        end
    end

endmodule // pc_trace_output_unit
`default_nettype wire

// ---- tb/trace_probe.sv ----
// Purpose: external probe model that captures the trace pins
// Assumes: the forwarded trace clock runs free at one eighth of the core rate
// Notes: captured values are read by the bench after each rise
`timescale 1ns/1ps
`default_nettype none
module trace_probe (
    // forwarded trace clock
    output var logic trace_clk,
    // trace pins in, captured values out
    input wire logic [2:0] trace_status,
    input wire logic trace_pin,
    output var logic [2:0] cap_status,
    output var logic cap_pin
);
    // free-running 160 ns clock, phase unrelated to the core clock
    initial begin
        trace_clk = 1'b0;
        #13;
        forever #80 trace_clk = ~trace_clk;
    end
    // sample status and data together on the rising trace clock
    always @(posedge trace_clk) begin
        cap_status <= trace_status;
        cap_pin <= trace_pin;
    end
endmodule // trace_probe
`default_nettype wire

// ---- tb/pc_trace_output_unit_props.sv ----
// Purpose: port-level properties of the trace output unit
// Assumes: trace ticks are at least 8 core clocks apart
// Notes: bound to every instance of the unit
`timescale 1ns/1ps
`default_nettype none
`include "pc_trace_defs.vh"
module pc_trace_output_unit_props (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // mode and instruction events
    input wire logic trace_complete_select,
    input wire logic debug_mode,
    input wire logic jump_direct,
    input wire logic branch,
    input wire logic taken,
    input wire logic jump_indirect,
    input wire logic exception_return_instr,
    input wire logic exception_event,
    input wire logic debug_exception,
    input wire logic serial_test_data,
    // outputs watched
    input wire logic core_stall,
    input wire logic [2:0] trace_status,
    input wire logic trace_pin,
    input wire logic pin_is_test_data
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // reset values, pin ownership and the debug entry code
    a_reset_values: assert property (disable iff (1'b0) !nrst |=>
        trace_status == `RST_STATUS && !trace_pin && !pin_is_test_data) else $error("bad reset");
    a_debug_pin: assert property (debug_mode |=>
        pin_is_test_data && trace_pin == $past(serial_test_data)) else $error("pin not test data");
    a_trace_owns_pin: assert property (!debug_mode |=> !pin_is_test_data)
        else $error("pin flag in trace mode");
    a_debug_code: assert property (debug_mode [*8] ##1 debug_mode [*2] |->
        trace_status == `CODE_DEBUG_ENTRY) else $error("no debug entry code");
    // outputs move only once per trace period
    a_status_hold: assert property ($changed(trace_status) && !debug_mode &&
        !$past(debug_mode) |=> $stable(trace_status) [*5]) else $error("status moved early");
    a_pin_hold: assert property ($changed(trace_pin) && !pin_is_test_data &&
        !$past(pin_is_test_data) |=> $stable(trace_pin) [*5]) else $error("pin moved early");
    // stalls and codes tied to their causes
    a_stall_cause: assert property (core_stall |-> trace_complete_select &&
        (jump_indirect || exception_event || exception_return_instr)) else $error("bad stall");
    a_jump_cause: assert property ($changed(trace_status) &&
        trace_status == `CODE_JUMP_TAKEN |-> $past(taken || exception_return_instr))
        else $error("jump code without jump");
    a_branch_cause: assert property ($changed(trace_status) &&
        trace_status == `CODE_BRANCH_TAKEN |-> $past(taken && (jump_direct || branch)))
        else $error("branch code without branch");
    a_exc_cause: assert property ($changed(trace_status) &&
        trace_status == `CODE_EXCEPTION |-> $past(exception_event && !debug_exception))
        else $error("exception code without cause");
endmodule // pc_trace_output_unit_props
bind pc_trace_output_unit pc_trace_output_unit_props pc_trace_output_unit_props_inst (
    .clock, .nrst, .trace_complete_select, .debug_mode, .jump_direct, .branch, .taken,
    .jump_indirect, .exception_return_instr, .exception_event, .debug_exception,
    .serial_test_data, .core_stall, .trace_status, .trace_pin, .pin_is_test_data);
`default_nettype wire

// ---- tb/pc_trace_output_unit_bench.sv ----
// Purpose: self-checking bench of the trace output unit
// Assumes: one instruction per trace period, held until the next rise
// Notes: results are read from the probe model one period later
`timescale 1ns/1ps
`default_nettype none
module pc_trace_output_unit_bench;
    localparam [9:0] f_v = 10'h001, f_n = 10'h002, f_jd = 10'h004, f_ji = 10'h008;
    localparam [9:0] f_br = 10'h010, f_tk = 10'h020, f_er = 10'h040, f_ex = 10'h080;
    localparam [9:0] f_dx = 10'h100, f_tr = 10'h200;
    localparam [31:0] pa = 32'hc3a5_96f4, pb = 32'h5a0f_e71c;
    logic clock, nrst, trace_complete_select, compressed_mode_strap, debug_mode;
    logic instr_valid, slot_nullified, jump_direct, jump_indirect, branch, taken;
    logic exception_return_instr, exception_event, debug_exception, trigger_match;
    logic serial_test_data, stall_code;
    logic [3:0] exception_vector;
    logic [31:0] target_pc;
    wire trace_clk, core_stall, trace_pin, pin_is_test_data, cap_pin;
    wire [2:0] trace_status, cap_status;
    integer mismatches, n_compared;
    // unit under test and the probe on its pins
    pc_trace_output_unit pc_trace_output_unit_inst (.clock, .nrst, .trace_clk,
        .trace_complete_select, .compressed_mode_strap, .debug_mode, .instr_valid,
        .slot_nullified, .jump_direct, .jump_indirect, .branch, .taken,
        .exception_return_instr, .exception_event, .exception_vector, .debug_exception,
        .trigger_match, .target_pc, .serial_test_data, .core_stall, .trace_status,
        .trace_pin, .pin_is_test_data);
    trace_probe trace_probe_inst (.trace_clk, .trace_status, .trace_pin, .cap_status, .cap_pin);
    // core clock, 20 ns
    always #10 clock = ~clock;
    task chk(input logic ok, input string what);
        n_compared = n_compared + 1;
        if (ok !== 1'b1) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task set_flags(input [9:0] f);
        {trigger_match, debug_exception, exception_event, exception_return_instr, taken,
            branch, jump_indirect, jump_direct, slot_nullified, instr_valid} <= f;
    endtask
    // reset for two cycles, then wait for the synchroniser and a fresh rise
    task do_reset(input logic strap);
        @(posedge clock);
        nrst <= 1'b0;
        compressed_mode_strap <= strap;
        trace_complete_select <= 1'b0;
        debug_mode <= 1'b0;
        set_flags(10'h000);
        @(posedge clock);
        #1 chk(trace_status === 3'h3 && trace_pin === 1'b0 && pin_is_test_data === 1'b0, "reset");
        @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        @(posedge trace_clk);
        #1;
    endtask
    // one instruction for one trace period; stall is sampled before the tick
    task step(input [9:0] f, input [31:0] pc, input [3:0] vec);
        @(posedge clock);
        set_flags(f);
        target_pc <= pc;
        exception_vector <= vec;
        @(posedge clock);
        #1 stall_code = core_stall;
        @(posedge trace_clk);
        #1;
    endtask
    task addr_bits(input [31:0] pc, input integer lo, input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            step(f_v, 32'h0, 4'h0);
            chk(cap_pin === pc[lo + i], "serial bit");
        end
    endtask
    task t_codes;
        logic [9:0] fl [0:5];
        logic [2:0] ex [0:5];
        integer i;
        fl = '{f_v, f_v | f_tr, f_v | f_br, f_v | f_n, f_v | f_n | f_tr, 10'h000};
        ex = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h2, 3'h3};
        do_reset(1'b0);
        for (i = 0; i < 6; i = i + 1) begin
            step(fl[i], pa, 4'h0);
            chk(cap_status === ex[i] && cap_pin === 1'b0, "code");
        end
        $display("codes done");
    endtask
    task t_indirect;
        do_reset(1'b0);
        step(f_v | f_ji | f_tk, pa, 4'h0);
        chk(cap_status === 3'h4 && cap_pin === pa[2], "indirect");
        addr_bits(pa, 3, 9);
        step(f_v | f_er, pb, 4'h0);
        chk(cap_status === 3'h4 && cap_pin === pb[2], "abort");
        addr_bits(pb, 3, 29);
        addr_bits(32'h0, 0, 2);
        step(f_v | f_br | f_tk, pa, 4'h0);
        chk(cap_status === 3'h4 && cap_pin === pa[2], "branch when idle");
        step(f_v | f_jd | f_tk, pb, 4'h0);
        chk(cap_status === 3'h5 && cap_pin === pa[3], "direct while busy");
        addr_bits(pa, 4, 28);
        addr_bits(32'h0, 0, 2);
        do_reset(1'b1);
        step(f_v | f_ji | f_tk, pa, 4'h0);
        chk(cap_pin === pa[1], "compressed start");
        addr_bits(pa, 2, 29);
        $display("jumps done");
    endtask
    task t_exception;
        do_reset(1'b0);
        step(f_v | f_ji | f_tk, pa, 4'h0);
        addr_bits(pa, 3, 3);
        step(f_v | f_ex, 32'h0, 4'ha);
        chk(cap_status === 3'h6 && cap_pin === 1'b0, "exception");
        step(f_v | f_ex, 32'h0, 4'h5);
        chk(cap_status === 3'h6 && cap_pin === 1'b1, "second exception");
        addr_bits(32'h5, 1, 3);
        addr_bits(pa, 6, 26);
        step(f_v | f_ex, 32'h0, 4'h6);
        step(f_v | f_jd | f_tk, pb, 4'h0);
        chk(cap_status === 3'h4 && cap_pin === 1'b1, "direct after exception");
        addr_bits(32'h6, 2, 2);
        // the buffered target starts one trace period after the vector ends
        addr_bits(32'h0, 0, 1);
        addr_bits(pb, 2, 30);
        $display("exceptions done");
    endtask
    task t_debug;
        do_reset(1'b0);
        step(f_v | f_ex | f_dx, 32'h0, 4'h9);
        chk(cap_status === 3'h3 && cap_pin === 1'b0, "debug exception");
        @(posedge clock);
        debug_mode <= 1'b1;
        serial_test_data <= 1'b1;
        step(f_v, 32'h0, 4'h0);
        chk(cap_status === 3'h7 && cap_pin === 1'b1 && pin_is_test_data === 1'b1, "debug");
        @(posedge clock);
        serial_test_data <= 1'b0;
        step(f_v, 32'h0, 4'h0);
        chk(cap_pin === 1'b0, "test data");
        @(posedge clock);
        debug_mode <= 1'b0;
        step(f_v, 32'h0, 4'h0);
        chk(cap_status === 3'h0 && pin_is_test_data === 1'b0, "trace again");
        $display("debug done");
    endtask
    // complete mode: buffer one target, stall on the next, withdraw it
    task t_complete;
        do_reset(1'b0);
        @(posedge clock);
        trace_complete_select <= 1'b1;
        step(f_v | f_ji | f_tk, pa, 4'h0);
        step(f_v | f_ji | f_tk, pb, 4'h0);
        chk(stall_code === 1'b0 && cap_pin === pa[3], "buffered");
        step(f_v | f_ji | f_tk, 32'h1234_5678, 4'h0);
        chk(stall_code === 1'b1 && cap_status === 3'h3 && cap_pin === pa[4], "stall");
        addr_bits(pa, 5, 27);
        addr_bits(32'h0, 0, 1);
        addr_bits(pb, 2, 30);
        $display("complete mode done");
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        trace_complete_select = 1'b0;
        compressed_mode_strap = 1'b0;
        debug_mode = 1'b0;
        serial_test_data = 1'b0;
        target_pc = 32'h0;
        exception_vector = 4'h0;
        set_flags(10'h000);
        mismatches = 0;
        n_compared = 0;
        t_codes;
        t_indirect;
        t_exception;
        t_debug;
        t_complete;
        tally_and_finish;
    end
    // about 250 trace periods are expected; allow several times that
    initial begin
        #250000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // pc_trace_output_unit_bench
`default_nettype wire
